// *** core/crossing_consts.vh ***
// Constants for the zero-cross event logic.
// Assumes an APB slave with 32-bit data, byte addresses, one word per register.
`ifndef CROSSING_CONSTS_VH
`define CROSSING_CONSTS_VH
// Register byte offsets
`define ADDR_CONTROL    12'h000
`define ADDR_FLAGS      12'h004
`define ADDR_ENABLES    12'h008
`define ADDR_INTCTL     12'h00C
`define ADDR_STATUS     12'h010
// Control register fields
`define CTL_ENABLE      7
`define CTL_OUTPUT      5
`define CTL_INVERT      4
`define CTL_RISE        1
`define CTL_FALL        0
// Flag, enable and interrupt control fields
`define FLAG_BIT        4
`define INTCTL_GLOBAL   7
`define INTCTL_PERIPH   6
// Status register fields
`define STAT_ACTIVE     0
`define STAT_DRIVE      1
`define STAT_SINK       2
`define STAT_SLEEP      3
`define WORD_ZERO       32'h0000_0000
`endif

// *** core/zero_cross_event_logic.v ***
// Zero-cross detector digital side with an APB register slave.
// Assumes sink_active arrives asynchronously from the analog sense stage.
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "crossing_consts.vh"

module zero_cross_event_logic (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        sink_active,
  input  wire        crossing_detector_config_n,
  input  wire        sleep_mode,
  input  wire        pin_dir_out,
  input  wire        pin_select_out,
  output reg         detector_active,
  output reg         pin_drive_current,
  output reg         pin_output_enable,
  output reg         crossing_logic_output,
  output reg         irq
);

  reg        enable_bit;
  reg        output_invert;
  reg        rise_irq_enable;
  reg        fall_irq_enable;
  reg        crossing_irq_flag;
  reg        crossing_irq_enable;
  reg        peripheral_irq_enable;
  reg        global_irq_enable;
  reg        sync_first;
  reg        sync_second;
  reg        prev_output;
  reg        config_n_seen;
  wire       adjusted_output;
  wire       rise_edge;
  wire       fall_edge;
  wire       set_flag;
  wire       wr;
  wire       rd;
  wire       mapped;
  wire       clear_flag;
  wire       active_now;
  wire       next_irq;
  reg [31:0] next_rdata;

  assign wr = psel & penable & pwrite & ~pready;
  assign rd = psel & penable & ~pwrite & ~pready;
  assign mapped = (paddr == `ADDR_CONTROL) | (paddr == `ADDR_FLAGS) |
                  (paddr == `ADDR_ENABLES) | (paddr == `ADDR_INTCTL) |
                  (paddr == `ADDR_STATUS);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_first <= 1'b0;
    end else begin
      sync_first <= sink_active;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_second <= 1'b0;
    end else begin
      sync_second <= sync_first;
    end
  end

  assign adjusted_output = sync_second ^ output_invert;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_output <= 1'b0;
    end else begin
      prev_output <= adjusted_output;
    end
  end

  assign rise_edge = adjusted_output & ~prev_output;
  assign fall_edge = ~adjusted_output & prev_output;
  wire       rise_hit;
  wire       fall_hit;
  assign rise_hit  = rise_edge & rise_irq_enable;
  assign fall_hit  = fall_edge & fall_irq_enable;
  assign set_flag  = rise_hit | fall_hit;
  assign clear_flag = wr & (paddr == `ADDR_FLAGS) & pwdata[`FLAG_BIT];

  // Configuration bit registered on every clock after reset release
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_n_seen <= 1'b1;
    end else begin
      config_n_seen <= crossing_detector_config_n;
    end
  end

  assign active_now = ~config_n_seen | enable_bit;

  // Register write strobes
  wire       wr_control;
  wire       wr_enables;
  wire       wr_intctl;

  assign wr_control = wr & (paddr == `ADDR_CONTROL);
  assign wr_enables = wr & (paddr == `ADDR_ENABLES);
  assign wr_intctl  = wr & (paddr == `ADDR_INTCTL);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_bit <= 1'b0;
    end else if (wr_control) begin
      enable_bit <= pwdata[`CTL_ENABLE];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_invert <= 1'b0;
    end else if (wr_control) begin
      output_invert <= pwdata[`CTL_INVERT];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_irq_enable <= 1'b0;
    end else if (wr_control) begin
      rise_irq_enable <= pwdata[`CTL_RISE];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fall_irq_enable <= 1'b0;
    end else if (wr_control) begin
      fall_irq_enable <= pwdata[`CTL_FALL];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crossing_irq_enable <= 1'b0;
    end else if (wr_enables) begin
      crossing_irq_enable <= pwdata[`FLAG_BIT];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peripheral_irq_enable <= 1'b0;
    end else if (wr_intctl) begin
      peripheral_irq_enable <= pwdata[`INTCTL_PERIPH];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_irq_enable <= 1'b0;
    end else if (wr_intctl) begin
      global_irq_enable <= pwdata[`INTCTL_GLOBAL];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crossing_irq_flag <= 1'b0;
    end else if (set_flag) begin
      crossing_irq_flag <= 1'b1;
    end else if (clear_flag) begin
      crossing_irq_flag <= 1'b0;
    end
  end

  assign next_irq = crossing_irq_flag & crossing_irq_enable &
                    peripheral_irq_enable & global_irq_enable;

  // Read data mux
  always @* begin
    next_rdata = `WORD_ZERO;
    case (paddr)
      `ADDR_CONTROL: begin
        next_rdata[`CTL_ENABLE] = enable_bit;
        next_rdata[`CTL_OUTPUT] = adjusted_output;
        next_rdata[`CTL_INVERT] = output_invert;
        next_rdata[`CTL_RISE]   = rise_irq_enable;
        next_rdata[`CTL_FALL]   = fall_irq_enable;
      end
      `ADDR_FLAGS: begin
        next_rdata[`FLAG_BIT] = crossing_irq_flag;
      end
      `ADDR_ENABLES: begin
        next_rdata[`FLAG_BIT] = crossing_irq_enable;
      end
      `ADDR_INTCTL: begin
        next_rdata[`INTCTL_GLOBAL] = global_irq_enable;
        next_rdata[`INTCTL_PERIPH] = peripheral_irq_enable;
      end
      `ADDR_STATUS: begin
        next_rdata[`STAT_ACTIVE] = active_now;
        next_rdata[`STAT_DRIVE]  = active_now;
        next_rdata[`STAT_SINK]   = sync_second;
        next_rdata[`STAT_SLEEP]  = sleep_mode;
      end
      default: begin
        next_rdata = `WORD_ZERO;
      end
    endcase
  end

  // APB handshake states, one wait state
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_DONE = 2'b10;

  reg [1:0]  state;
  reg [1:0]  next_state;

  always @* begin
    next_state = ST_IDLE;
    case (state)
      ST_IDLE: begin
        if (psel & penable) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // APB answer flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `WORD_ZERO;
    end else begin
      pready  <= (next_state == ST_DONE);
      pslverr <= (next_state == ST_DONE) & ~mapped;
      if (rd) begin
        prdata <= next_rdata;
      end
    end
  end

  // Pin and status outputs, all registered

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      detector_active <= 1'b0;
    end else begin
      detector_active <= active_now;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_drive_current <= 1'b0;
    end else begin
      pin_drive_current <= active_now;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_output_enable <= 1'b0;
    end else begin
      pin_output_enable <= active_now | (pin_dir_out & pin_select_out);
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crossing_logic_output <= 1'b0;
    end else begin
      crossing_logic_output <= adjusted_output;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

endmodule // zero_cross_event_logic

// *** tb/analog_sense_model.sv ***
// Sense stage model: sinks above the crossing reference, sources below.
// Assumes the bench gives the applied pin voltage in millivolts.
`timescale 1ns/1ps
module analog_sense_model #(
  parameter int crossing_reference_voltage = 750
) (
  input  var int   applied_mv,
  output logic     sink_active
);
  assign sink_active = applied_mv > crossing_reference_voltage;
endmodule // analog_sense_model

// *** tb/crossing_checker.sv ***
// Port checker for the zero-cross event logic.
// Assumes it is bound to zero_cross_event_logic.
`timescale 1ns/1ps
module crossing_checker (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire [11:0] paddr,
  input wire        pready,
  input wire        pslverr,
  input wire        crossing_detector_config_n,
  input wire        pin_dir_out,
  input wire        pin_select_out,
  input wire        detector_active,
  input wire        pin_drive_current,
  input wire        pin_output_enable
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_wait_a: assert property (psel && penable && !pready |=> pready) else $error("late");
  ready_pulse_a: assert property (pready |=> !pready) else $error("held");
  error_ready_a: assert property (pslverr |-> pready) else $error("lone error");
  error_decode_a: assert property (pready && paddr[1:0] == 2'b00
    |-> pslverr == (paddr > 12'h010)) else $error("decode");
  strap_on_a: assert property (!crossing_detector_config_n [*4] |-> detector_active)
    else $error("strap");
  drive_on_a: assert property (detector_active && $past(detector_active)
    |-> pin_drive_current && pin_output_enable) else $error("drive on");
  drive_off_a: assert property (!detector_active && !$past(detector_active)
    |-> !pin_drive_current) else $error("drive off");
  pin_free_a: assert property (!detector_active && !$past(detector_active) && $past(presetn)
    |-> pin_output_enable == ($past(pin_dir_out) && $past(pin_select_out))) else $error("pin");
  cover property (pslverr);
  cover property (pin_output_enable && !detector_active);
  cover property (detector_active && !crossing_detector_config_n);
endmodule // crossing_checker

bind zero_cross_event_logic crossing_checker crossing_checker_inst (.pclk, .presetn, .psel,
  .penable, .paddr, .pready, .pslverr, .crossing_detector_config_n, .pin_dir_out,
  .pin_select_out, .detector_active, .pin_drive_current, .pin_output_enable);

// *** tb/zero_cross_event_logic_bench.sv ***
// Bench: APB master, sense model, table of output cases, interrupt tests.
// Assumes core/ is on the include path.
`timescale 1ns/1ps
`include "crossing_consts.vh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module zero_cross_event_logic_bench;
  logic [2:0]  rows [4] = '{3'b101, 3'b000, 3'b110, 3'b011};
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic        crossing_detector_config_n = 1, sleep_mode = 0, pin_select_out = 0;
  logic        pin_dir_out = 1;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        pready, pslverr, sink_active, detector_active, pin_drive_current;
  logic        pin_output_enable, crossing_logic_output, irq;
  int          mv = 0, num_errors = 0, n_checks = 0;
  analog_sense_model analog_sense_model_inst (.applied_mv(mv), .sink_active);
  zero_cross_event_logic zero_cross_event_logic_inst (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sink_active,
    .crossing_detector_config_n, .sleep_mode, .pin_dir_out, .pin_select_out,
    .detector_active, .pin_drive_current, .pin_output_enable, .crossing_logic_output, .irq);
  initial forever #12.5 pclk = ~pclk;
  task complete_run;
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk) penable <= 1;
    i = 0;
    do begin @(posedge pclk); i++; end while (pready !== 1 && i < 20);
    if (i == 20) begin num_errors++; complete_run; end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    apb(0, `ADDR_CONTROL, 0);
    `CHK("ctl", 32'h0000_0000, rd)
    `CHK("act", 1'b0, detector_active)
    for (int k = 0; k < 4; k++) begin
      mv <= rows[k][2] ? 1000 : 100;
      apb(1, `ADDR_CONTROL, 32'h0000_0080 | (32'(rows[k][1]) << 4));
      apb(0, `ADDR_CONTROL, 0);
      `CHK("out_bit", rows[k][0], rd[5])
      `CHK("out_pin", rows[k][0], crossing_logic_output)
    end
    `CHK("act_on", 1'b1, detector_active)
    apb(1, `ADDR_INTCTL, 32'h0000_00C0);
    apb(1, `ADDR_ENABLES, 32'h0000_0010);
    pin_select_out <= 1;
    apb(1, `ADDR_CONTROL, 32'h0000_0002);
    apb(0, `ADDR_FLAGS, 0);
    `CHK("fall_off", 32'h0000_0000, rd)
    `CHK("pin_oe", 1'b1, pin_output_enable)
    pin_dir_out <= 0;
    sleep_mode <= 1;
    mv <= 1000;
    repeat (5) @(posedge pclk);
    apb(0, `ADDR_FLAGS, 0);
    `CHK("rise_on", 32'h0000_0010, rd)
    `CHK("irq_on", 1'b1, irq)
    `CHK("pin_oe_off", 1'b0, pin_output_enable)
    apb(1, `ADDR_ENABLES, 0);
    apb(0, `ADDR_FLAGS, 0);
    `CHK("irq_mask", 1'b0, irq)
    apb(1, `ADDR_FLAGS, 32'h0000_0010);
    apb(0, `ADDR_FLAGS, 0);
    `CHK("clear", 32'h0000_0000, rd)
    mv <= 100;
    repeat (4) @(posedge pclk);
    mv <= 1000;
    apb(1, `ADDR_FLAGS, 32'h0000_0010);
    apb(0, `ADDR_FLAGS, 0);
    `CHK("set_wins", 32'h0000_0010, rd)
    apb(1, `ADDR_FLAGS, 32'h0000_0010);
    apb(1, `ADDR_CONTROL, 32'h0000_0011);
    repeat (2) @(posedge pclk);
    apb(0, `ADDR_FLAGS, 0);
    `CHK("inv_edge", 32'h0000_0010, rd)
    crossing_detector_config_n <= 0;
    apb(1, `ADDR_CONTROL, 0);
    apb(0, `ADDR_STATUS, 0);
    `CHK("forced", 1'b1, rd[`STAT_ACTIVE])
    `CHK("drive", 1'b1, pin_drive_current)
    `CHK("sleep", 1'b1, rd[`STAT_SLEEP])
    apb(0, 12'h020, 0);
    `CHK("unmapped", 1'b1, err)
    `CHK("unm_data", 32'h0000_0000, rd)
    @(posedge pclk) presetn <= 0;
    @(posedge pclk);
    `CHK("rst_act", 1'b0, detector_active)
    `CHK("rst_irq", 1'b0, irq)
    presetn <= 1;
    repeat (3) @(posedge pclk);
    `CHK("strap_on", 1'b1, detector_active)
    complete_run;
  end
endmodule // zero_cross_event_logic_bench
